// [core/cmd_pkg.sv]
/*
  shared constants and carrier types for the command register bank.
  assumes a 32-bit apb master and one 25 mhz system clock.
*/
`default_nettype none
package cmd_pkg;
  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] CMD_ADDR = 12'h000;
  localparam logic [11:0] WDOG_ADDR = 12'h004;
  localparam logic [11:0] MASK_ADDR = 12'h008;
  localparam logic [11:0] STAT_ADDR = 12'h00c;
  // ****************************************************************
  // command word fields and reset values
  // ****************************************************************
  localparam int LOAD_FILTER = 9;
  localparam int FETCH_RES = 8;
  localparam int SOFT_RST = 7;
  localparam int TIMER_RUN = 5;
  localparam int TIMER_HALT = 4;
  localparam int RX_ON = 3;
  localparam int RX_OFF = 2;
  localparam int TX_GO = 1;
  localparam int TX_HALT = 0;
  localparam logic [15:0] CMD_HW_RESET = 16'h0094;
  localparam logic [15:0] SRST_CLEAR = 16'h0303;
  localparam logic [15:0] SRST_SET = 16'h0084;
  localparam logic [15:0] CMD_SETTABLE = 16'h033f;
  localparam int MASK_TIMER = 0;
  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic filter_load_done;
    logic resource_fetch_done;
    logic tx_end_of_list;
    logic tx_halt_taken;
    logic tx_abort;
    logic rx_packet_active;
  } engine_status_t;
  typedef struct packed {
    logic filter_load_go;
    logic resource_fetch_go;
    logic tx_go;
    logic tx_halt;
    logic rx_buffering;
    logic sm_reset;
    logic crc_disable;
    logic tally_halt;
  } engine_ctrl_t;
endpackage : cmd_pkg
`default_nettype wire

// [core/apb_port.sv]
/*
  apb slave front end: one wait state, flags unmapped addresses.
  assumes the master holds its request until pready is seen high.
*/
`timescale 1ns/1ps
`default_nettype none
module apb_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  // decoded request
  output cmd_pkg::reg_req_t req
);
  typedef struct packed {
    logic ack;
  } port_state_t;
  port_state_t state;
  port_state_t next_state;
  logic mapped;

  // decode: only the four aligned words answer without error
  always_comb begin
    mapped = (paddr == cmd_pkg::CMD_ADDR) || (paddr == cmd_pkg::WDOG_ADDR) ||
             (paddr == cmd_pkg::MASK_ADDR) || (paddr == cmd_pkg::STAT_ADDR);
    next_state.ack = psel && penable && !state.ack;
    req.wr = psel && penable && state.ack && pwrite && mapped;
    req.rd = psel && penable && !state.ack && !pwrite;
    req.addr = paddr;
    req.wdata = pwdata;
    pready = state.ack;
    pslverr = state.ack && !mapped;
  end

  // ack flop gives the single wait state used to register read data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : apb_port
`default_nettype wire

// [core/wdog_timer.sv]
/*
  general purpose down counter with load, run and hold.
  assumes load and run come from the command bank on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module wdog_timer #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic run,
  input wire logic hold,
  // state
  output logic [WIDTH-1:0] count,
  output logic expired
);
  if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
    $error("wdog_timer width must lie in 2..32");
  end
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic expired;
  } timer_state_t;
  timer_state_t state;
  timer_state_t next_state;
  logic stepping;

  // decrement only while running and not held in soft reset
  always_comb begin
    next_state = state;
    stepping = run && !hold && (state.count != '0);
    next_state.expired = stepping && (state.count == WIDTH'(1));
    if (load) begin
      next_state.count = load_value;
    end else if (stepping) begin
      next_state.count = state.count - WIDTH'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;
  assign expired = state.expired;
endmodule : wdog_timer
`default_nettype wire

// [core/cmd_register.sv]
/*
  command register bank: self-clearing commands to the filter, resource
  and transmit engines, receive on and off, soft reset hold, watchdog control.
  assumes engines answer with one-cycle done pulses on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmd_register #(
  parameter int TIMER_WIDTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // engines
  input wire cmd_pkg::engine_status_t engine_status,
  output cmd_pkg::engine_ctrl_t engine_ctrl,
  // timer interrupt
  output logic timer_irq
);
  if (TIMER_WIDTH != 32) begin : g_bad_timer
    $error("cmd_register supports a 32-bit watchdog only");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] cmd;
    logic timer_mask;
    logic rx_buffering;
    logic last_rx_on;
    logic irq;
    logic [31:0] rdata;
  } bank_state_t;
  bank_state_t state;
  bank_state_t next_state;
  cmd_pkg::reg_req_t req;
  logic [TIMER_WIDTH-1:0] count;
  logic expired;
  logic wr_cmd;
  logic wr_wdog;
  logic [15:0] wbits;
  logic tx_finished;

  // ****************************************************************
  // bus front end and watchdog
  // ****************************************************************
  apb_port apb_port_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .req(req)
  );

  // run gate: counts only with run set
  wdog_timer #(.WIDTH(TIMER_WIDTH)) wdog_timer_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .load(wr_wdog),
    .load_value(req.wdata),
    .run(state.cmd[cmd_pkg::TIMER_RUN]),
    .hold(state.cmd[cmd_pkg::SOFT_RST]),
    .count(count),
    .expired(expired)
  );

  // write decode for the two registers with side effects
  assign wr_cmd = req.wr && (req.addr == cmd_pkg::CMD_ADDR);
  assign wr_wdog = req.wr && (req.addr == cmd_pkg::WDOG_ADDR);
  assign wbits = req.wdata[15:0];
  assign tx_finished = engine_status.tx_end_of_list || engine_status.tx_halt_taken ||
                       engine_status.tx_abort;

  // ****************************************************************
  // next state: completions first, writes last so a set wins
  // ****************************************************************
  always_comb begin
    next_state = state;
    if (engine_status.filter_load_done) begin
      next_state.cmd[cmd_pkg::LOAD_FILTER] = 1'b0;
    end
    if (engine_status.resource_fetch_done) begin
      next_state.cmd[cmd_pkg::FETCH_RES] = 1'b0;
    end
    if (tx_finished) begin
      next_state.cmd[cmd_pkg::TX_GO] = 1'b0;
    end
    if (tx_finished || !state.cmd[cmd_pkg::TX_GO]) begin
      next_state.cmd[cmd_pkg::TX_HALT] = 1'b0;
    end
    // receive engine held off in soft reset
    if (state.cmd[cmd_pkg::SOFT_RST]) begin
      next_state.rx_buffering = 1'b0;
    end else if (!engine_status.rx_packet_active) begin
      // enable takes effect only between packets
      if (state.cmd[cmd_pkg::RX_ON] && (!state.cmd[cmd_pkg::RX_OFF] || state.last_rx_on)) begin
        next_state.rx_buffering = 1'b1;
        next_state.cmd[cmd_pkg::RX_OFF] = 1'b0;
      end else if (state.cmd[cmd_pkg::RX_OFF]) begin
        next_state.rx_buffering = 1'b0;
        next_state.cmd[cmd_pkg::RX_ON] = 1'b0;
      end
    end
    next_state.irq = expired && state.timer_mask;
    if (req.wr && (req.addr == cmd_pkg::MASK_ADDR)) begin
      next_state.timer_mask = req.wdata[cmd_pkg::MASK_TIMER];
    end
    if (wr_cmd) begin
      if (state.cmd[cmd_pkg::SOFT_RST]) begin
        // only the reset bit moves while in reset
        next_state.cmd[cmd_pkg::SOFT_RST] = wbits[cmd_pkg::SOFT_RST];
      end else if (wbits[cmd_pkg::SOFT_RST]) begin
        next_state.cmd = (next_state.cmd & ~cmd_pkg::SRST_CLEAR) | cmd_pkg::SRST_SET;
      end else begin
        // ones set, zeros ignored; reserved never stored
        next_state.cmd = next_state.cmd | (wbits & cmd_pkg::CMD_SETTABLE);
        if (wbits[cmd_pkg::TIMER_RUN] && !wbits[cmd_pkg::TIMER_HALT]) begin
          next_state.cmd[cmd_pkg::TIMER_HALT] = 1'b0;
        end
        if (wbits[cmd_pkg::TIMER_HALT]) begin
          next_state.cmd[cmd_pkg::TIMER_RUN] = 1'b0;
        end
        if (wbits[cmd_pkg::RX_ON] || wbits[cmd_pkg::RX_OFF]) begin
          next_state.last_rx_on = wbits[cmd_pkg::RX_ON] && !wbits[cmd_pkg::RX_OFF];
        end
      end
    end
    // read data captured in the wait cycle, reserved reads as zero
    if (req.rd) begin
      unique case (req.addr)
        cmd_pkg::CMD_ADDR: next_state.rdata = {16'h0000, state.cmd};
        cmd_pkg::WDOG_ADDR: next_state.rdata = count;
        cmd_pkg::MASK_ADDR: next_state.rdata = {31'h00000000, state.timer_mask};
        cmd_pkg::STAT_ADDR: next_state.rdata = {30'h00000000, count == '0, state.rx_buffering};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= '0;
      state.cmd <= cmd_pkg::CMD_HW_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // requests held off during soft reset
  always_comb begin
    engine_ctrl.filter_load_go = state.cmd[cmd_pkg::LOAD_FILTER] && !state.cmd[cmd_pkg::SOFT_RST];
    engine_ctrl.resource_fetch_go = state.cmd[cmd_pkg::FETCH_RES] && !state.cmd[cmd_pkg::SOFT_RST];
    engine_ctrl.tx_go = state.cmd[cmd_pkg::TX_GO] && !state.cmd[cmd_pkg::SOFT_RST];
    engine_ctrl.tx_halt = state.cmd[cmd_pkg::TX_HALT] && !state.cmd[cmd_pkg::SOFT_RST];
    engine_ctrl.rx_buffering = state.rx_buffering;
    engine_ctrl.sm_reset = state.cmd[cmd_pkg::SOFT_RST];
    engine_ctrl.crc_disable = state.cmd[cmd_pkg::SOFT_RST];
    engine_ctrl.tally_halt = state.cmd[cmd_pkg::SOFT_RST];
  end
  assign prdata = state.rdata;
  assign timer_irq = state.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_hw_reset;
    @(posedge sys_clk) srst |=> state.cmd == cmd_pkg::CMD_HW_RESET;
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("hw reset value wrong");

  property p_soft_reset;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && wbits[7] && !state.cmd[7]
      |=> ((state.cmd & 16'h0387) == 16'h0084) && (state.cmd[3] == $past(state.cmd[3]));
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset pattern wrong");

  property p_self_clear;
    @(posedge sys_clk) disable iff (srst)
      engine_status.filter_load_done && !(wr_cmd && wbits[9]) |=> !state.cmd[9];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("filter bit not cleared");

  property p_zero_write;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && !wbits[9] && !wbits[7] && state.cmd[9] && !state.cmd[7] && !engine_status.filter_load_done
      |=> state.cmd[9];
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared a bit");

  property p_timer_still;
    @(posedge sys_clk) disable iff (srst)
      (!state.cmd[5] || state.cmd[7]) && !wr_wdog |=> count == $past(count);
  endproperty
  a_timer_still: assert property (p_timer_still) else $error("timer moved while stopped");

  property p_irq_mask;
    @(posedge sys_clk) disable iff (srst) expired |=> timer_irq == $past(state.timer_mask);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("timer irq mask ignored");

  property p_both_stop;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && wbits[5] && wbits[4] && !wbits[7] && !state.cmd[7] |=> state.cmd[4] && !state.cmd[5];
  endproperty
  a_both_stop: assert property (p_both_stop) else $error("run and halt left timer running");

  property p_run_clears_halt;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && wbits[5] && !wbits[4] && !wbits[7] && !state.cmd[7] |=> state.cmd[5] && !state.cmd[4];
  endproperty
  a_run_clears_halt: assert property (p_run_clears_halt) else $error("run did not clear halt");

  property p_rst_hold;
    @(posedge sys_clk) disable iff (srst)
      state.cmd[7] |-> !engine_ctrl.tx_go && engine_ctrl.tally_halt ##1 !engine_ctrl.rx_buffering;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("engines active in soft reset");

  property p_rx_packet;
    @(posedge sys_clk) disable iff (srst)
      engine_status.rx_packet_active && state.rx_buffering && !state.cmd[7] |=> state.rx_buffering;
  endproperty
  a_rx_packet: assert property (p_rx_packet) else $error("receive stopped mid packet");

  property p_tx_end;
    @(posedge sys_clk) disable iff (srst) tx_finished && !(wr_cmd && wbits[1]) |=> !state.cmd[1];
  endproperty
  a_tx_end: assert property (p_tx_end) else $error("transmit bit not cleared");

  // a plain command write raises its go line on the next cycle
  property p_filter_go;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && wbits[cmd_pkg::LOAD_FILTER] && !wbits[cmd_pkg::SOFT_RST] && !state.cmd[cmd_pkg::SOFT_RST]
      |=> engine_ctrl.filter_load_go;
  endproperty
  a_filter_go: assert property (p_filter_go) else $error("filter load not started");

  property p_fetch_go;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && wbits[cmd_pkg::FETCH_RES] && !wbits[cmd_pkg::SOFT_RST] && !state.cmd[cmd_pkg::SOFT_RST]
      |=> engine_ctrl.resource_fetch_go;
  endproperty
  a_fetch_go: assert property (p_fetch_go) else $error("resource fetch not started");

  property p_halt_clears_run;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && wbits[cmd_pkg::TIMER_HALT] && !wbits[cmd_pkg::SOFT_RST] && !state.cmd[cmd_pkg::SOFT_RST]
      |=> state.cmd[cmd_pkg::TIMER_HALT] && !state.cmd[cmd_pkg::TIMER_RUN];
  endproperty
  a_halt_clears_run: assert property (p_halt_clears_run) else $error("halt left timer running");

  // a running timer steps down by exactly one per cycle
  property p_count_step;
    @(posedge sys_clk) disable iff (srst)
      state.cmd[cmd_pkg::TIMER_RUN] && !state.cmd[cmd_pkg::SOFT_RST] && !wr_wdog && count != '0
      |=> count == $past(count) - 32'h00000001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("running timer did not step");

  // receive state follows the enable bits once the wire is quiet
  property p_rx_on_idle;
    @(posedge sys_clk) disable iff (srst)
      state.cmd[cmd_pkg::RX_ON] && !state.cmd[cmd_pkg::RX_OFF] && !state.cmd[cmd_pkg::SOFT_RST] &&
      !engine_status.rx_packet_active |=> state.rx_buffering;
  endproperty
  a_rx_on_idle: assert property (p_rx_on_idle) else $error("receive on did not buffer");

  property p_rx_off_idle;
    @(posedge sys_clk) disable iff (srst)
      state.cmd[cmd_pkg::RX_OFF] && !state.cmd[cmd_pkg::RX_ON] && !engine_status.rx_packet_active
      |=> !state.rx_buffering;
  endproperty
  a_rx_off_idle: assert property (p_rx_off_idle) else $error("receive off still buffering");

  // transmit halt lives as long as the transmit that it stops
  property p_halt_hold;
    @(posedge sys_clk) disable iff (srst)
      state.cmd[cmd_pkg::TX_HALT] && state.cmd[cmd_pkg::TX_GO] && !tx_finished && !wr_cmd
      |=> state.cmd[cmd_pkg::TX_HALT];
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped before transmit stopped");

  property p_halt_release;
    @(posedge sys_clk) disable iff (srst)
      tx_finished && !(wr_cmd && wbits[cmd_pkg::TX_HALT]) |=> !state.cmd[cmd_pkg::TX_HALT];
  endproperty
  a_halt_release: assert property (p_halt_release) else $error("halt kept after transmit ended");

  // no filter, fetch or transmit command survives a write made while soft reset is still set
  property p_reset_write;
    @(posedge sys_clk) disable iff (srst)
      wr_cmd && state.cmd[cmd_pkg::SOFT_RST] |=> !state.cmd[cmd_pkg::LOAD_FILTER] &&
      !state.cmd[cmd_pkg::FETCH_RES] && !state.cmd[cmd_pkg::TX_GO] && !state.cmd[cmd_pkg::TX_HALT];
  endproperty
  a_reset_write: assert property (p_reset_write) else $error("command taken during soft reset");

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (srst)
      (state.cmd & ~(cmd_pkg::CMD_SETTABLE | cmd_pkg::SRST_SET)) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored");

  c_soft_release: cover property (@(posedge sys_clk) state.cmd[7] ##1 !state.cmd[7]);
  c_timer_irq: cover property (@(posedge sys_clk) timer_irq);
  c_rx_on: cover property (@(posedge sys_clk) !state.rx_buffering ##1 state.rx_buffering);
  c_tx_done: cover property (@(posedge sys_clk) state.cmd[1] ##1 !state.cmd[1]);
  c_rx_off: cover property (@(posedge sys_clk) state.rx_buffering ##1 !state.rx_buffering);
endmodule : cmd_register
`default_nettype wire

// [verif/tb.sv]
/*
  self-checking bench for the command register bank, driven over apb.
  assumes one 25 mhz clock, engines replaced by bench-driven done pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************************************************************
  // clock, reset and design hookup
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cmd_pkg::engine_status_t engine_status = '0;
  cmd_pkg::engine_ctrl_t engine_ctrl;
  logic timer_irq;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] rdat;
  logic [31:0] held;
  logic rerr;

  // free-running 40 ns clock
  always #20 sys_clk = ~sys_clk;

  cmd_register #(.TIMER_WIDTH(32)) cmd_register_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .engine_status(engine_status), .engine_ctrl(engine_ctrl), .timer_irq(timer_irq));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_check(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(what, exp, rdat);
  endtask : rd_check

  // done pulses last exactly one cycle, as the engines give them
  task automatic pulse(input logic [5:0] p);
    @(posedge sys_clk);
    engine_status <= cmd_pkg::engine_status_t'(p);
    @(posedge sys_clk);
    engine_status <= '0;
  endtask : pulse

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic reset_scn;
    rd_check("command after reset", cmd_pkg::CMD_ADDR, 32'h00000094);
    check("engine hold", 32'h000000e0 >> 5, {29'h0, engine_ctrl[2:0]});
    rd_check("mask after reset", cmd_pkg::MASK_ADDR, 32'h00000000);
    // the command bit in this write must be dropped while reset is set
    wr(cmd_pkg::CMD_ADDR, 32'h00000200);
    rd_check("command after release", cmd_pkg::CMD_ADDR, 32'h00000014);
    check("engine released", 32'h0, {24'h0, engine_ctrl});
  endtask : reset_scn

  task automatic rx_scn;
    @(posedge sys_clk);
    engine_status.rx_packet_active <= 1'b1;
    wr(cmd_pkg::CMD_ADDR, 32'h00000008);
    rd_check("rx on mid packet", cmd_pkg::CMD_ADDR, 32'h0000001c);
    rd_check("no buffering mid packet", cmd_pkg::STAT_ADDR, 32'h00000002);
    @(posedge sys_clk);
    engine_status.rx_packet_active <= 1'b0;
    rd_check("rx on idle", cmd_pkg::CMD_ADDR, 32'h00000018);
    rd_check("buffering on", cmd_pkg::STAT_ADDR, 32'h00000003);
    check("rx buffering line", 32'h1, {31'h0, engine_ctrl.rx_buffering});
    @(posedge sys_clk);
    engine_status.rx_packet_active <= 1'b1;
    wr(cmd_pkg::CMD_ADDR, 32'h00000004);
    rd_check("rx off mid packet", cmd_pkg::CMD_ADDR, 32'h0000001c);
    rd_check("buffering kept", cmd_pkg::STAT_ADDR, 32'h00000003);
    @(posedge sys_clk);
    engine_status.rx_packet_active <= 1'b0;
    rd_check("rx off idle", cmd_pkg::CMD_ADDR, 32'h00000014);
    rd_check("buffering off", cmd_pkg::STAT_ADDR, 32'h00000002);
  endtask : rx_scn

  // set a command, see zero writes ignored, finish it, see it self-clear
  task automatic cmd_scn(input logic [15:0] setv, input logic [5:0] done, input string what);
    // never sets filter load and transmit together: the device would hang
    // bench keeps apart
    wr(cmd_pkg::CMD_ADDR, {16'h0, setv & 16'hfffe});
    if (setv[0]) wr(cmd_pkg::CMD_ADDR, 32'h00000001);
    rd_check(what, cmd_pkg::CMD_ADDR, {16'h0, setv | 16'h0014});
    check("go lines", {28'h0, setv[9], setv[8], setv[1], setv[0]}, {28'h0, engine_ctrl[7:4]});
    wr(cmd_pkg::CMD_ADDR, 32'h00000000);
    rd_check(what, cmd_pkg::CMD_ADDR, {16'h0, setv | 16'h0014});
    pulse(done);
    rd_check(what, cmd_pkg::CMD_ADDR, 32'h00000014);
    check("go lines idle", 32'h0, {28'h0, engine_ctrl[7:4]});
  endtask : cmd_scn

  task automatic timer_scn;
    int hits = 0;
    wr(cmd_pkg::WDOG_ADDR, 32'd40);
    rd_check("count before run", cmd_pkg::WDOG_ADDR, 32'd40);
    rd_check("count before run", cmd_pkg::WDOG_ADDR, 32'd40);
    wr(cmd_pkg::CMD_ADDR, 32'h00000020);
    rd_check("run clears halt", cmd_pkg::CMD_ADDR, 32'h00000024);
    held = rdat;
    apb(1'b0, cmd_pkg::WDOG_ADDR, 32'h0);
    held = rdat;
    apb(1'b0, cmd_pkg::WDOG_ADDR, 32'h0);
    check("counting down", 32'h1, {31'h0, rdat < held && held < 32'd40});
    wr(cmd_pkg::CMD_ADDR, 32'h00000010);
    rd_check("halt clears run", cmd_pkg::CMD_ADDR, 32'h00000014);
    apb(1'b0, cmd_pkg::WDOG_ADDR, 32'h0);
    held = rdat;
    rd_check("count held", cmd_pkg::WDOG_ADDR, held);
    wr(cmd_pkg::CMD_ADDR, 32'h00000020);
    wr(cmd_pkg::CMD_ADDR, 32'h00000030);
    apb(1'b0, cmd_pkg::WDOG_ADDR, 32'h0);
    held = rdat;
    rd_check("run and halt stop", cmd_pkg::WDOG_ADDR, held);
    // enabled expiry gives exactly one pulse
    wr(cmd_pkg::MASK_ADDR, 32'h00000001);
    wr(cmd_pkg::CMD_ADDR, 32'h00000020);
    repeat (150) begin
      @(posedge sys_clk);
      if (timer_irq === 1'b1) hits++;
    end
    check("enabled expiry pulses", 32'd1, hits);
    rd_check("count at zero", cmd_pkg::WDOG_ADDR, 32'h0);
    // masked expiry stays quiet
    wr(cmd_pkg::CMD_ADDR, 32'h00000010);
    wr(cmd_pkg::MASK_ADDR, 32'h00000000);
    wr(cmd_pkg::WDOG_ADDR, 32'd3);
    wr(cmd_pkg::CMD_ADDR, 32'h00000020);
    hits = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (timer_irq === 1'b1) hits++;
    end
    check("masked expiry pulses", 32'd0, hits);
    wr(cmd_pkg::CMD_ADDR, 32'h00000010);
  endtask : timer_scn

  task automatic soft_scn;
    wr(cmd_pkg::CMD_ADDR, 32'h0000fc40);
    rd_check("reserved read zero", cmd_pkg::CMD_ADDR, 32'h00000014);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", 32'h1, {31'h0, rerr});
    check("unmapped data", 32'h0, rdat);
    wr(cmd_pkg::CMD_ADDR, 32'h00000008);
    wr(cmd_pkg::WDOG_ADDR, 32'd100);
    wr(cmd_pkg::CMD_ADDR, 32'h00000020);
    rd_check("before soft reset", cmd_pkg::CMD_ADDR, 32'h00000028);
    wr(cmd_pkg::CMD_ADDR, 32'h00000080);
    rd_check("soft reset value", cmd_pkg::CMD_ADDR, 32'h000000ac);
    check("engines held", 32'h7, {29'h0, engine_ctrl[2:0]});
    apb(1'b0, cmd_pkg::WDOG_ADDR, 32'h0);
    held = rdat;
    rd_check("timer frozen", cmd_pkg::WDOG_ADDR, held);
    wr(cmd_pkg::CMD_ADDR, 32'h00000280);
    rd_check("command refused", cmd_pkg::CMD_ADDR, 32'h000000ac);
    check("go lines low", 32'h0, {28'h0, engine_ctrl[7:4]});
  endtask : soft_scn

  // ****************************************************************
  // verdict, main sequence and watchdog
  // ****************************************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    reset_scn();
    rx_scn();
    cmd_scn(16'h0200, 6'h20, "filter load");
    cmd_scn(16'h0100, 6'h10, "resource fetch");
    cmd_scn(16'h0002, 6'h08, "transmit to end");
    cmd_scn(16'h0002, 6'h02, "transmit abort");
    cmd_scn(16'h0003, 6'h04, "transmit halt");
    timer_scn();
    soft_scn();
    final_report();
  end

  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    final_report();
  end
endmodule : tb
`default_nettype wire
